/* design/pqe_pkg.sv */
// Constants of the programmable quadrature encoder output logic
package pqe_pkg;
  // Sensor steps per shaft revolution (one revolution is 200 mm of wire)
  localparam int unsigned SNS_BITS = 14;
  localparam logic [14:0] RES_MIN = 15'h0001;
  localparam logic [14:0] RES_MAX = 15'h4000;
  localparam logic [14:0] RES_DEF = 15'h4000;
  // Clock rate and output frequency limit of each max-speed option
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned OPT0_KHZ = 75;
  localparam int unsigned OPT1_KHZ = 150;
  localparam int unsigned OPT2_KHZ = 300;
  localparam int unsigned OPT3_KHZ = 600;
  // Least spacing between two quadrature edges, in clock cycles
  localparam logic [11:0] GAP0 = 12'(CLK_KHZ / (4 * OPT0_KHZ));
  localparam logic [11:0] GAP1 = 12'(CLK_KHZ / (4 * OPT1_KHZ));
  localparam logic [11:0] GAP2 = 12'(CLK_KHZ / (4 * OPT2_KHZ));
  localparam logic [11:0] GAP3 = 12'(CLK_KHZ / (4 * OPT3_KHZ));
  // Shaft speed of each option in rpm
  localparam logic [31:0] RPM0 = 32'h0000_0232;
  localparam logic [31:0] RPM1 = 32'h0000_0465;
  localparam logic [31:0] RPM2 = 32'h0000_08ca;
  localparam logic [31:0] RPM3 = 32'h0000_1194;
  // Largest rpm times resolution product the counter input can follow
  localparam logic [31:0] CNT_LIMIT = 32'h0232_8000;
  localparam logic [1:0] SPD_DEF = 2'h2;
  // Backlog of edges owed to the outputs before an overrun is flagged
  localparam logic signed [7:0] PEND_MAX = 8'sh40;
  // Error code bits
  localparam int unsigned ERR_OVR = 0;
  localparam int unsigned ERR_SNS = 1;
endpackage

/* design/pqe_encoder.sv */
// Quadrature output logic of the programmable draw-wire encoder
// Function
// R01 - CCW: extension makes A lead B
// R02 - CW: phase relation reversed
// R03 - Narrow index: 90 degrees, A and B high
// R04 - Wide index: 180 degrees, A high
// R05 - One index per revolution at fixed point
// R06 - Index set stores current angle
// R07 - Factory settings give 16384 pulses per revolution
// R08 - Resolution clamped to 1..16384
// R09 - Resolution write clears position count
// R10 - Max-speed option limits edge rate
// R11 - Status warning and clear-error command
// R12 - Persisting fault keeps its error code
// R13 - Position counter follows edges and direction
// R14 - Operator resets index after resolution change
`timescale 1ns/1ps
module pqe_encoder (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sns_step,
  input wire logic sns_ext,
  input wire logic sns_fault,
  input wire logic cfg_res_wr,
  input wire logic [15:0] cfg_res_val,
  input wire logic cfg_dir_cw,
  input wire logic cfg_idx_wide,
  input wire logic [1:0] cfg_speed,
  input wire logic cmd_idx_set,
  input wire logic cmd_factory,
  input wire logic cmd_clr_err,
  output logic enc_a,
  output logic enc_b,
  output logic enc_idx,
  output logic [31:0] pos_count,
  output logic [14:0] res_now,
  output logic [1:0] speed_eff,
  output logic stat_warn,
  output logic [1:0] err_code
);

  typedef struct packed {
    logic [14:0] res;
    logic [13:0] acc;
    logic signed [7:0] pend;
    logic [11:0] gap;
    logic [16:0] rev;
    logic [16:0] idx;
    logic [31:0] pos;
    logic [1:0] err;
    logic [1:0] spd;
    logic warn;
    logic a;
    logic b;
    logic z;
  } pqe_state_type;

  pqe_state_type q;
  pqe_state_type d;
  logic emit;
  logic emit_fwd;

  function automatic logic [11:0] pqe_gap(input logic [1:0] opt);
    logic [11:0] g;
    unique case (opt)
      2'h0: g = pqe_pkg::GAP0;
      2'h1: g = pqe_pkg::GAP1;
      2'h2: g = pqe_pkg::GAP2;
      2'h3: g = pqe_pkg::GAP3;
    endcase
    return g;
  endfunction

  // Requested option, capped at the fastest one whose edge rate the resolution still allows
  function automatic logic [1:0] pqe_spd_limit(input logic [1:0] opt,
                                               input logic [14:0] res);
    logic [31:0] r;
    logic [1:0] top;
    r = {17'h00000, res};
    top = 2'h0;
    if (32'(pqe_pkg::RPM1 * r) <= pqe_pkg::CNT_LIMIT)
      top = 2'h1;
    if (32'(pqe_pkg::RPM2 * r) <= pqe_pkg::CNT_LIMIT)
      top = 2'h2;
    if (32'(pqe_pkg::RPM3 * r) <= pqe_pkg::CNT_LIMIT)
      top = 2'h3;
    return (opt > top) ? top : opt;
  endfunction

  function automatic logic [14:0] pqe_clamp(input logic [15:0] v);
    logic [14:0] r;
    if (v < {1'b0, pqe_pkg::RES_MIN})
      r = pqe_pkg::RES_MIN;
    else if (v > {1'b0, pqe_pkg::RES_MAX})
      r = pqe_pkg::RES_MAX;
    else
      r = v[14:0];
    return r;
  endfunction

  always_comb
  begin
    logic [16:0] edges4;
    logic [16:0] last;
    logic [17:0] sum;
    logic [2:0] n;
    logic signed [8:0] np;
    logic [1:0] ph;
    logic pa;
    logic pb;
    d = q;
    emit = 1'b0;
    emit_fwd = 1'b0;
    edges4 = {q.res, 2'b00};
    last = 17'(edges4 - 17'h00001);
    sum = 18'h00000;
    n = 3'h0;
    np = 9'(q.pend);
    ph = 2'h0;
    pa = 1'b0;
    pb = 1'b0;
    d.spd = pqe_spd_limit(cfg_speed, q.res); // R10
    // Clear first, so a fault or overrun seen this cycle wins
    if (cmd_clr_err)
      d.err = 2'h0; // R11
    // Fractional scaling of sensor steps to quadrature edges
    if (sns_step)
    begin
      if (sns_ext)
      begin
        sum = 18'({4'h0, q.acc} + {1'b0, edges4});
        n = sum[16:14];
        np = 9'(np + $signed({6'h00, n}));
      end
      else
      begin
        sum = 18'({4'h0, q.acc} + 18'h10000 - {1'b0, edges4});
        n = 3'(3'h4 - sum[16:14]);
        np = 9'(np - $signed({6'h00, n}));
      end
      d.acc = sum[13:0];
    end
    // Edge generator paced by the max-speed spacing
    if (q.gap != 12'h000)
      d.gap = 12'(q.gap - 12'h001);
    else if (np != 9'sh000)
    begin
      emit = 1'b1; // R10
      emit_fwd = (np > 9'sh000);
      d.gap = pqe_gap(d.spd); // R10
      np = emit_fwd ? 9'(np - 9'sh001) : 9'(np + 9'sh001);
    end
    // Backlog beyond the limit is an overrun warning
    if (np > 9'(pqe_pkg::PEND_MAX))
    begin
      np = 9'(pqe_pkg::PEND_MAX);
      d.err[pqe_pkg::ERR_OVR] = 1'b1; // R11
    end
    else if (np < -9'(pqe_pkg::PEND_MAX))
    begin
      np = -9'(pqe_pkg::PEND_MAX);
      d.err[pqe_pkg::ERR_OVR] = 1'b1; // R11
    end
    d.pend = np[7:0];
    if (emit)
    begin
      if (emit_fwd)
        d.rev = (q.rev == last) ? 17'h00000 : 17'(q.rev + 17'h00001); // R05
      else
        d.rev = (q.rev == 17'h00000) ? last : 17'(q.rev - 17'h00001); // R05
      // Count up on extension for CCW, on rewind for CW
      if (emit_fwd ^ cfg_dir_cw)
        d.pos = 32'(q.pos + 32'h0000_0001); // R13
      else
        d.pos = 32'(q.pos - 32'h0000_0001); // R13
    end
    if (cmd_idx_set)
      d.idx = q.rev; // R06
    if (sns_fault)
      d.err[pqe_pkg::ERR_SNS] = 1'b1; // R12
    if (cfg_res_wr)
    begin
      d.res = pqe_clamp(cfg_res_val); // R08
      d.pos = 32'h0000_0000; // R09
      d.acc = 14'h0000;
      d.pend = 8'sh00;
      d.rev = 17'h00000;
      d.idx = 17'h00000;
    end
    if (cmd_factory)
    begin
      d.res = pqe_pkg::RES_DEF; // R07
      d.pos = 32'h0000_0000;
      d.acc = 14'h0000;
      d.pend = 8'sh00;
      d.rev = 17'h00000;
      d.idx = 17'h00000;
    end
    d.warn = (d.err != 2'h0); // R11
    // Phase sequence 00,10,11,01 on extension makes A lead
    ph = d.rev[1:0];
    pa = (ph == 2'h1) || (ph == 2'h2);
    pb = (ph == 2'h2) || (ph == 2'h3);
    d.a = cfg_dir_cw ? pb : pa; // R01 R02
    d.b = cfg_dir_cw ? pa : pb; // R01 R02
    if (d.rev[16:2] != d.idx[16:2])
      d.z = 1'b0; // R05
    else if (cfg_idx_wide)
      d.z = d.a; // R04
    else
      d.z = d.a && d.b; // R03
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.res <= pqe_pkg::RES_DEF; // R07
      q.spd <= pqe_pkg::SPD_DEF;
    end
    else
      q <= d;
  end

  assign enc_a = q.a;
  assign enc_b = q.b;
  assign enc_idx = q.z;
  assign pos_count = q.pos;
  assign res_now = q.res;
  assign speed_eff = q.spd;
  assign stat_warn = q.warn;
  assign err_code = q.err;

  default clocking pqe_cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  logic quiet;
  assign quiet = !cfg_res_wr && !cmd_factory;

  AST_CCW_A_LEADS: assert property ( // R01
    emit && emit_fwd && quiet && !cfg_dir_cw ##1 !cfg_dir_cw
    |-> enc_a == !$past(enc_b) && enc_b == $past(enc_a))
    else $error("A does not lead B on extension");

  AST_CW_REVERSED: assert property ( // R02
    emit && emit_fwd && quiet && cfg_dir_cw ##1 cfg_dir_cw
    |-> enc_b == !$past(enc_a) && enc_a == $past(enc_b))
    else $error("phase not reversed in CW mode");

  AST_CCW_REWIND: assert property ( // R01
    emit && !emit_fwd && quiet && !cfg_dir_cw ##1 !cfg_dir_cw
    |-> enc_b == !$past(enc_a) && enc_a == $past(enc_b))
    else $error("B does not lead A on rewind");

  AST_IDX_NARROW: assert property ( // R03
    enc_idx && !$past(cfg_idx_wide) |-> enc_a && enc_b)
    else $error("narrow index outside A and B high");

  AST_IDX_WIDE: assert property ( // R04
    enc_idx && $past(cfg_idx_wide) |-> enc_a)
    else $error("wide index outside A high");

  AST_IDX_POINT: assert property ( // R05
    enc_idx |-> q.rev[16:2] == q.idx[16:2] && q.rev < {q.res, 2'b00})
    else $error("index away from stored point");

  AST_IDX_SET: assert property ( // R06
    cmd_idx_set && quiet |=> q.idx == $past(q.rev))
    else $error("index point not captured");

  AST_FACTORY_RES: assert property ( // R07
    cmd_factory |=> res_now == pqe_pkg::RES_DEF ##1 1'b1)
    else $error("factory resolution wrong");

  AST_RES_RANGE: assert property ( // R08
    res_now >= pqe_pkg::RES_MIN && res_now <= pqe_pkg::RES_MAX)
    else $error("resolution out of range");

  AST_RES_CLR_POS: assert property ( // R09
    cfg_res_wr |=> pos_count == 32'h0000_0000)
    else $error("position not cleared on resolution write");

  AST_EDGE_GAP: assert property ( // R10
    emit |=> q.gap == pqe_gap($past(d.spd)) && !emit)
    else $error("edge spacing violated");

  AST_FAULT_KEPT: assert property ( // R12
    sns_fault && cmd_clr_err |=> err_code[pqe_pkg::ERR_SNS] && stat_warn)
    else $error("persisting fault code lost");

  AST_OVR_SET: assert property ( // R11
    sns_step && sns_ext && quiet && q.res == pqe_pkg::RES_MAX
    && q.pend == pqe_pkg::PEND_MAX |=> err_code[pqe_pkg::ERR_OVR])
    else $error("edge overrun not flagged");

  AST_CLR_ERR: assert property ( // R11
    cmd_clr_err && !sns_fault && !sns_step |=> err_code == 2'h0)
    else $error("error code not cleared");

  AST_POS_STEP: assert property ( // R13
    emit && quiet |=> pos_count != $past(pos_count))
    else $error("position counter missed an edge");

endmodule // pqe_encoder

/* verif/pqe_qcnt.sv */
// Counter model of the electronics that receives the quadrature outputs
`timescale 1ns/1ps
module pqe_qcnt (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_idx,
  input wire logic idx_wide,
  output logic signed [31:0] q_count,
  output logic [15:0] idx_seen,
  output logic [15:0] idx_bad
);
  logic [1:0] ph_q;
  logic idx_q;
  logic [1:0] ph;
  logic [1:0] step;
  // Phase number rises by one per edge while A leads B
  assign ph = {enc_b, enc_a ^ enc_b};
  assign step = 2'(ph - ph_q);
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ph_q <= 2'h0;
      idx_q <= 1'b0;
      q_count <= 32'sh0;
      idx_seen <= 16'h0;
      idx_bad <= 16'h0;
    end
    else
    begin
      ph_q <= ph;
      idx_q <= enc_idx;
      if (step == 2'h1)
        q_count <= q_count + 32'sh1;
      else if (step == 2'h3)
        q_count <= q_count - 32'sh1;
      if (enc_idx && !idx_q)
        idx_seen <= idx_seen + 16'h1;
      if (enc_idx && !(enc_a && (enc_b || idx_wide)))
        idx_bad <= idx_bad + 16'h1;
    end
  end
endmodule // pqe_qcnt

/* verif/pqe_encoder_tb.sv */
// Self-checking bench of the quadrature encoder output logic
`timescale 1ns/1ps
module pqe_encoder_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sns_step = 1'b0, sns_ext = 1'b0, sns_fault = 1'b0, cfg_res_wr = 1'b0;
  logic [15:0] cfg_res_val = 16'h0;
  logic cfg_dir_cw = 1'b0, cfg_idx_wide = 1'b0, cmd_idx_set = 1'b0;
  logic [1:0] cfg_speed = 2'h2;
  logic cmd_factory = 1'b0, cmd_clr_err = 1'b0;
  logic enc_a, enc_b, enc_idx, stat_warn;
  logic [31:0] pos_count, q_count, qb, pb;
  logic [14:0] res_now;
  logic [1:0] speed_eff, err_code;
  logic [15:0] idx_seen, idx_bad, ib;
  int n_fail = 0, checks_done = 0, cyc = 0;
  pqe_encoder dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .sns_step(sns_step), .sns_ext(sns_ext), .sns_fault(sns_fault),
    .cfg_res_wr(cfg_res_wr), .cfg_res_val(cfg_res_val),
    .cfg_dir_cw(cfg_dir_cw), .cfg_idx_wide(cfg_idx_wide),
    .cfg_speed(cfg_speed), .cmd_idx_set(cmd_idx_set),
    .cmd_factory(cmd_factory), .cmd_clr_err(cmd_clr_err), .enc_a(enc_a),
    .enc_b(enc_b), .enc_idx(enc_idx), .pos_count(pos_count),
    .res_now(res_now), .speed_eff(speed_eff), .stat_warn(stat_warn),
    .err_code(err_code));
  pqe_qcnt cnt (.core_clk(core_clk), .sys_rst(sys_rst), .enc_a(enc_a),
    .enc_b(enc_b), .enc_idx(enc_idx), .idx_wide(cfg_idx_wide),
    .q_count(q_count), .idx_seen(idx_seen), .idx_bad(idx_bad));
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("mismatches %0d of %0d checks", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Pulse one command for one cycle: 0 res write, 1 index set, 2 factory, 3 clear
  task automatic pls(input int k, input logic [15:0] v);
    @(posedge core_clk);
    cfg_res_val <= v;
    cfg_res_wr <= (k == 0);
    cmd_idx_set <= (k == 1);
    cmd_factory <= (k == 2);
    cmd_clr_err <= (k == 3);
    @(posedge core_clk);
    {cfg_res_wr, cmd_idx_set, cmd_factory, cmd_clr_err} <= 4'h0;
    wt(3);
  endtask
  // Back-to-back sensor steps, wire pulled out when ext is high
  task automatic steps(input int n, input int w, input logic ext);
    @(posedge core_clk);
    sns_step <= 1'b1;
    sns_ext <= ext;
    repeat (n) @(posedge core_clk);
    sns_step <= 1'b0;
    wt(w);
  endtask
  task automatic t_dir(input logic cw);
    @(posedge core_clk);
    cfg_dir_cw <= cw;
    wt(2);
    qb = q_count;
    pb = pos_count;
    steps(1, 1000, 1'b1);
    chk(q_count - qb, cw ? 32'hffff_fffc : 32'h4);
    chk(pos_count - pb, cw ? 32'hffff_fffc : 32'h4);
    steps(1, 1000, 1'b0);
    chk(q_count - qb, 32'h0);
    chk(pos_count - pb, 32'h0);
  endtask
  task automatic t_res();
    pls(0, 16'h0);
    chk(32'(res_now), 32'h1);
    chk(pos_count, 32'h0);
    pls(0, 16'h4e20);
    chk(32'(res_now), 32'h4000);
    @(posedge core_clk);
    cfg_speed <= 2'h3;
    cfg_dir_cw <= 1'b0;
    wt(3);
    chk(32'(speed_eff), 32'h2);
    pls(0, 16'h1);
    chk(32'(speed_eff), 32'h3);
  endtask
  task automatic t_index();
    ib = idx_seen;
    steps(16384, 300, 1'b1);
    chk(32'(idx_seen - ib), 32'h1);
    @(posedge core_clk);
    cfg_idx_wide <= 1'b1;
    steps(16384, 300, 1'b1);
    chk(32'(idx_seen - ib), 32'h2);
    chk(32'(idx_bad), 32'h0);
    @(posedge core_clk);
    cfg_idx_wide <= 1'b0;
    pls(0, 16'h2);
    steps(8192, 300, 1'b1);
    pls(1, 16'h2);
    ib = idx_seen;
    steps(8192, 300, 1'b1);
    chk(32'(idx_seen - ib), 32'h1);
  endtask
  task automatic t_fault();
    @(posedge core_clk);
    sns_fault <= 1'b1;
    wt(3);
    pls(3, 16'h2);
    chk(32'(err_code[1]), 32'h1);
    chk(32'(stat_warn), 32'h1);
    @(posedge core_clk);
    sns_fault <= 1'b0;
    pls(3, 16'h2);
    chk(32'(err_code), 32'h0);
    chk(32'(stat_warn), 32'h0);
    pls(2, 16'h2);
    chk(32'(res_now), 32'h4000);
    chk(pos_count, 32'h0);
    steps(20, 3, 1'b1);
    chk(32'(err_code), 32'h1);
    chk(32'(stat_warn), 32'h1);
    pls(3, 16'h2);
    chk(32'(err_code), 32'h0);
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    wt(1);
    chk(32'(res_now), 32'h4000);
    chk(32'(speed_eff), 32'h2);
    t_dir(1'b0);
    t_dir(1'b1);
    t_res();
    t_index();
    t_fault();
    complete_run();
  end
endmodule // pqe_encoder_tb
